// *** hdl/mstx_exec.sv ***
// execution unit for nibble exchange, nil skips, bit skips, table fetch and xor
module mstx_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // instruction from decoder
  input wire logic op_valid,
  input wire mstx_pkg::mstx_op_t op,
  input wire logic [mstx_pkg::MSTX_DW-1:0] mem_rdata,
  input wire logic [mstx_pkg::MSTX_DW-1:0] imm,
  input wire logic [mstx_pkg::MSTX_BITW-1:0] bit_sel,
  input wire logic [mstx_pkg::MSTX_PCW-1:0] pc,
  input wire logic [mstx_pkg::MSTX_DW-1:0] table_index_reg,
  // program rom read port
  input wire logic [mstx_pkg::MSTX_ROMW-1:0] rom_rdata,
  output logic rom_re,
  output logic [mstx_pkg::MSTX_PCW-1:0] rom_addr,
  // data memory write port
  output logic mem_we,
  output logic [mstx_pkg::MSTX_DW-1:0] mem_wdata,
  // architectural state
  output logic [mstx_pkg::MSTX_DW-1:0] acc,
  output logic [mstx_pkg::MSTX_DW-1:0] table_upper_byte_reg,
  output logic zero_flag,
  // pipeline control
  output logic discard_prefetch,
  output logic busy
);
  import mstx_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mstx_state_t st;
    logic [MSTX_DW-1:0] acc;
    logic [MSTX_DW-1:0] tbh;
    logic z;
    logic rom_re;
    logic [MSTX_PCW-1:0] rom_addr;
    logic mem_we;
    logic [MSTX_DW-1:0] mem_wdata;
    logic discard;
    logic busy;
  } mstx_regs_t;

  mstx_regs_t r_q;
  mstx_regs_t r_d;

  // alu results, all combinational from the current operands
  logic [MSTX_DW-1:0] swapped;
  logic [MSTX_DW-1:0] xor_mem;
  logic [MSTX_DW-1:0] xor_imm;
  logic mem_nil;
  logic xor_mem_nil;
  logic xor_imm_nil;
  logic bit_val;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  mstx_alu u_alu (
    .acc(r_q.acc),
    .mem(mem_rdata),
    .imm(imm),
    .bit_sel(bit_sel),
    .swapped(swapped),
    .xor_mem(xor_mem),
    .xor_imm(xor_imm),
    .mem_nil(mem_nil),
    .xor_mem_nil(xor_mem_nil),
    .xor_imm_nil(xor_imm_nil),
    .bit_val(bit_val)
  );

  // table address: page bits from pc or forced to the last page, offset from index
  function automatic logic [MSTX_PCW-1:0] table_addr(input logic last,
                                                     input logic [MSTX_PCW-1:0] p,
                                                     input logic [MSTX_DW-1:0] idx);
    logic [MSTX_PAGEW-1:0] page;
    // the last page is the top of the rom, whatever page the fetch runs in
    page = last ? MSTX_LAST_PAGE_HI : p[MSTX_PCW-1:MSTX_DW];
    return {page, idx};
  endfunction : table_addr

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // strobes default low so each write or discard lasts exactly one enabled cycle
  always_comb begin
    r_d = r_q;
    r_d.rom_re = 1'b0;
    r_d.mem_we = 1'b0;
    r_d.discard = 1'b0;
    r_d.busy = 1'b0;
    case (r_q.st)
      MSTX_ST_EXEC: begin
        if (op_valid) begin
          case (op)
            // accumulator loads leave the zero flag alone
            MSTX_OP_NIBBLE_EXCHANGE_TO_ACC: begin
              r_d.acc = swapped;
            end
            // a taken skip drops the prefetched word and spends one dummy cycle
            MSTX_OP_SKIP_WHEN_NIL: begin
              if (mem_nil) begin
                r_d.discard = 1'b1;
                r_d.busy = 1'b1;
                r_d.st = MSTX_ST_DUMMY;
              end
            end
            MSTX_OP_COPY_SKIP_NIL: begin
              r_d.acc = mem_rdata;
              if (mem_nil) begin
                r_d.discard = 1'b1;
                r_d.busy = 1'b1;
                r_d.st = MSTX_ST_DUMMY;
              end
            end
            MSTX_OP_SKIP_WHEN_BIT_CLR: begin
              if (!bit_val) begin
                r_d.discard = 1'b1;
                r_d.busy = 1'b1;
                r_d.st = MSTX_ST_DUMMY;
              end
            end
            MSTX_OP_SKIP_WHEN_BIT_SET: begin
              if (bit_val) begin
                r_d.discard = 1'b1;
                r_d.busy = 1'b1;
                r_d.st = MSTX_ST_DUMMY;
              end
            end
            MSTX_OP_TABLE_FETCH_THIS_PAGE, MSTX_OP_TABLE_FETCH_FINAL_PAGE: begin
              // rom port is shared with fetch, so the access costs a second cycle
              r_d.rom_re = 1'b1;
              r_d.rom_addr = table_addr(op == MSTX_OP_TABLE_FETCH_FINAL_PAGE, pc,
                                        table_index_reg);
              r_d.busy = 1'b1;
              r_d.st = MSTX_ST_TABLE;
            end
            // xor family: the zero flag follows the result as well
            MSTX_OP_XOR_ACC_MEM: begin
              r_d.acc = xor_mem;
              r_d.z = xor_mem_nil;
            end
            MSTX_OP_EXCLUSIVE_OR_TO_MEM: begin
              r_d.mem_we = 1'b1;
              r_d.mem_wdata = xor_mem;
              r_d.z = xor_mem_nil;
            end
            MSTX_OP_XOR_ACC_IMM: begin
              r_d.acc = xor_imm;
              r_d.z = xor_imm_nil;
            end
            default: begin
              // unknown codes do nothing, so a stray decode cannot corrupt state
            end
          endcase
        end
      end
      // dummy cycle: nothing executes, the decoder refetches
      MSTX_ST_DUMMY: begin
        r_d.st = MSTX_ST_EXEC;
      end
      // rom word is back: split it between memory and the upper byte register
      MSTX_ST_TABLE: begin
        r_d.mem_we = 1'b1;
        r_d.mem_wdata = rom_rdata[MSTX_DW-1:0];
        r_d.tbh = rom_rdata[MSTX_ROMW-1:MSTX_DW];
        r_d.st = MSTX_ST_EXEC;
      end
      default: begin
        r_d.st = MSTX_ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // clock enable freezes everything, including the one-cycle strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{st: MSTX_ST_EXEC,
               acc: MSTX_ACC_RST,
               tbh: MSTX_TBH_RST,
               z: 1'b0,
               rom_re: 1'b0,
               rom_addr: '0,
               mem_we: 1'b0,
               mem_wdata: '0,
               discard: 1'b0,
               busy: 1'b0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // outputs straight from flip-flops
  assign rom_re = r_q.rom_re;
  assign rom_addr = r_q.rom_addr;
  assign mem_we = r_q.mem_we;
  assign mem_wdata = r_q.mem_wdata;
  assign acc = r_q.acc;
  assign table_upper_byte_reg = r_q.tbh;
  assign zero_flag = r_q.z;
  assign discard_prefetch = r_q.discard;
  assign busy = r_q.busy;

endmodule : mstx_exec

// *** hdl/mstx_pkg.sv ***
// package of constants and types for the skip, table and xor execution block
package mstx_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned MSTX_DW = 8;
  localparam int unsigned MSTX_PCW = 13;
  localparam int unsigned MSTX_PAGEW = 5;
  localparam int unsigned MSTX_BITW = 3;
  localparam int unsigned MSTX_ROMW = 16;
  localparam int unsigned MSTX_NIBW = 4;

  // ----------------------------------------------------------------
  // operation codes presented by the core's decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MSTX_OP_NONE = 4'h0,
    MSTX_OP_NIBBLE_EXCHANGE_TO_ACC = 4'h1,
    MSTX_OP_SKIP_WHEN_NIL = 4'h2,
    MSTX_OP_COPY_SKIP_NIL = 4'h3,
    MSTX_OP_SKIP_WHEN_BIT_CLR = 4'h4,
    MSTX_OP_SKIP_WHEN_BIT_SET = 4'h5,
    MSTX_OP_TABLE_FETCH_THIS_PAGE = 4'h6,
    MSTX_OP_TABLE_FETCH_FINAL_PAGE = 4'h7,
    MSTX_OP_XOR_ACC_MEM = 4'h8,
    MSTX_OP_EXCLUSIVE_OR_TO_MEM = 4'h9,
    MSTX_OP_XOR_ACC_IMM = 4'ha
  } mstx_op_t;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MSTX_ST_EXEC = 3'h1,
    MSTX_ST_DUMMY = 3'h2,
    MSTX_ST_TABLE = 3'h4
  } mstx_state_t;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [MSTX_DW-1:0] MSTX_ZERO = 8'h00;
  localparam logic [MSTX_PAGEW-1:0] MSTX_LAST_PAGE_HI = 5'h1f;
  localparam logic [MSTX_DW-1:0] MSTX_ACC_RST = 8'h00;
  localparam logic [MSTX_DW-1:0] MSTX_TBH_RST = 8'h00;

endpackage : mstx_pkg

// *** hdl/mstx_alu.sv ***
// combinational data path: nibble exchange, xor, bit select and nil tests
module mstx_alu
  import mstx_pkg::*;
(
  // operands
  input wire logic [mstx_pkg::MSTX_DW-1:0] acc,
  input wire logic [mstx_pkg::MSTX_DW-1:0] mem,
  input wire logic [mstx_pkg::MSTX_DW-1:0] imm,
  input wire logic [mstx_pkg::MSTX_BITW-1:0] bit_sel,
  // results
  output logic [mstx_pkg::MSTX_DW-1:0] swapped,
  output logic [mstx_pkg::MSTX_DW-1:0] xor_mem,
  output logic [mstx_pkg::MSTX_DW-1:0] xor_imm,
  output logic mem_nil,
  output logic xor_mem_nil,
  output logic xor_imm_nil,
  output logic bit_val
);

  // zero test, shared by the skip and the flag logic
  function automatic logic is_nil(input logic [MSTX_DW-1:0] v);
    return v == MSTX_ZERO;
  endfunction : is_nil

  // pure combinational results
  always_comb begin
    swapped = {mem[MSTX_NIBW-1:0], mem[MSTX_DW-1:MSTX_NIBW]};
    xor_mem = acc ^ mem;
    xor_imm = acc ^ imm;
    mem_nil = is_nil(mem);
    xor_mem_nil = is_nil(xor_mem);
    xor_imm_nil = is_nil(xor_imm);
    bit_val = mem[bit_sel];
  end

endmodule : mstx_alu

// *** test/mstx_exec_monitor.sv ***
// checker of results and cycle timing for the skip, table and xor execution block
module mstx_exec_monitor
  import mstx_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire mstx_pkg::mstx_op_t op,
  // operands
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [12:0] pc,
  input wire logic [7:0] table_index_reg,
  input wire logic [15:0] rom_rdata,
  // results
  input wire logic rom_re,
  input wire logic [12:0] rom_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] table_upper_byte_reg,
  input wire logic zero_flag,
  input wire logic discard_prefetch,
  input wire logic busy
);
  logic nil_p, bit_p;
  logic [7:0] mem_p, x_p, xi_p;
  logic [12:0] tab_p, last_p;
  // one-cycle samples, so each result is compared with its own cause
  always_ff @(posedge clk) begin
    nil_p <= mem_rdata == 8'h00;
    bit_p <= mem_rdata[bit_sel];
    mem_p <= mem_rdata;
    x_p <= acc ^ mem_rdata;
    xi_p <= acc ^ imm;
    tab_p <= {pc[12:8], table_index_reg};
    last_p <= {5'h1f, table_index_reg};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  sequence s_take(mstx_op_t o);
    clk_en && op_valid && !busy && op == o;
  endsequence
  sequence s_skip(logic hit);
    discard_prefetch == hit && busy == hit && $stable(zero_flag);
  endsequence
  // a frozen cycle between fetch and store would move the store, so clk_en is required
  sequence s_tab(logic [12:0] a);
    rom_re && busy && rom_addr == a ##1
      mem_we && !busy && {table_upper_byte_reg, mem_wdata} == $past(rom_rdata);
  endsequence
  a_nibble_to_acc: assert property (s_take(MSTX_OP_NIBBLE_EXCHANGE_TO_ACC) |=>
    acc == {mem_p[3:0], mem_p[7:4]} && $stable(zero_flag) && !mem_we) else $error("nibble bad");
  a_nil_skip: assert property (s_take(MSTX_OP_SKIP_WHEN_NIL) |=> s_skip(nil_p))
    else $error("nil skip bad");
  a_copy_nil_skip: assert property (s_take(MSTX_OP_COPY_SKIP_NIL) |=>
    acc == mem_p ##0 s_skip(nil_p)) else $error("copy skip bad");
  a_bit_clr_skip: assert property (s_take(MSTX_OP_SKIP_WHEN_BIT_CLR) |=> s_skip(!bit_p))
    else $error("bit clear skip bad");
  a_bit_set_skip: assert property (s_take(MSTX_OP_SKIP_WHEN_BIT_SET) |=> s_skip(bit_p))
    else $error("bit set skip bad");
  a_table_this: assert property (s_take(MSTX_OP_TABLE_FETCH_THIS_PAGE) ##1 clk_en
    |-> s_tab(tab_p)) else $error("table this page bad");
  a_table_last: assert property (s_take(MSTX_OP_TABLE_FETCH_FINAL_PAGE) ##1 clk_en
    |-> s_tab(last_p)) else $error("table last page bad");
  a_xor_acc: assert property (s_take(MSTX_OP_XOR_ACC_MEM) |=>
    acc == x_p && zero_flag == (x_p == 8'h00) && !mem_we) else $error("xor acc bad");
  a_xor_mem: assert property (s_take(MSTX_OP_EXCLUSIVE_OR_TO_MEM) |=> mem_we &&
    mem_wdata == x_p && zero_flag == (x_p == 8'h00) && $stable(acc)) else $error("xor mem bad");
  a_xor_imm: assert property (s_take(MSTX_OP_XOR_ACC_IMM) |=>
    acc == xi_p && zero_flag == (xi_p == 8'h00)) else $error("xor imm bad");
  // the dummy or table cycle lasts one enabled cycle and starts nothing new
  a_busy_once: assert property (clk_en && busy |=>
    !busy && !discard_prefetch && !rom_re) else $error("busy too long");
endmodule : mstx_exec_monitor

bind mstx_exec mstx_exec_monitor u_mstx_exec_monitor (.clk, .rst_n, .clk_en, .op_valid, .op,
  .mem_rdata, .imm, .bit_sel, .pc, .table_index_reg, .rom_rdata, .rom_re, .rom_addr, .mem_we,
  .mem_wdata, .acc, .table_upper_byte_reg, .zero_flag, .discard_prefetch, .busy);

// *** test/tb_mstx_exec.sv ***
// testbench for the skip, table and xor execution block
module tb_mstx_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import mstx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  mstx_op_t op = MSTX_OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] imm = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [12:0] pc = 13'h0000;
  logic [7:0] table_index_reg = 8'h00;
  logic [15:0] rom_rdata = 16'h0000;
  logic rom_re, mem_we, zero_flag, discard_prefetch, busy;
  logic [12:0] rom_addr;
  logic [7:0] mem_wdata, acc, table_upper_byte_reg;
  int err_total = 0;
  int compares = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  mstx_exec u_mstx_exec (.clk, .rst_n, .clk_en, .op_valid, .op, .mem_rdata, .imm, .bit_sel,
    .pc, .table_index_reg, .rom_rdata, .rom_re, .rom_addr, .mem_we, .mem_wdata, .acc,
    .table_upper_byte_reg, .zero_flag, .discard_prefetch, .busy);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk
  // valid stays high on return, so calls may run back to back
  task automatic issue(input mstx_op_t o, input logic [7:0] m, input logic [7:0] i);
    op_valid = 1'b1;
    op = o;
    mem_rdata = m;
    imm = i;
    @(negedge clk);
  endtask : issue
  // stale operand is inverted so nothing leans on a held value
  task automatic idle();
    op_valid = 1'b0;
    mem_rdata = ~mem_rdata;
    @(negedge clk);
  endtask : idle
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_xor();
    issue(MSTX_OP_COPY_SKIP_NIL, 8'h5a, 8'h00);
    issue(MSTX_OP_EXCLUSIVE_OR_TO_MEM, 8'h3c, 8'h00);
    chk(acc === 8'h5a && mem_we === 1'b1 && mem_wdata === 8'h66, "xor to mem");
    issue(MSTX_OP_XOR_ACC_IMM, 8'h00, 8'ha5);
    chk(acc === 8'hff && zero_flag === 1'b0 && mem_we === 1'b0, "xor imm");
    issue(MSTX_OP_XOR_ACC_MEM, 8'hff, 8'h00);
    chk(acc === 8'h00 && zero_flag === 1'b1, "xor acc mem");
    issue(MSTX_OP_NIBBLE_EXCHANGE_TO_ACC, 8'ha5, 8'h00);
    chk(acc === 8'h5a && zero_flag === 1'b1 && mem_we === 1'b0, "nibble");
    idle();
  endtask : t_xor
  task automatic t_skip();
    logic [7:0] m;
    for (int k = 0; k < 4; k++) begin
      m = k[1] ? 8'h80 : 8'h00;
      issue(k[0] ? MSTX_OP_COPY_SKIP_NIL : MSTX_OP_SKIP_WHEN_NIL, m, 8'h00);
      chk(discard_prefetch === ~k[1] && busy === ~k[1], "nil");
      chk(zero_flag === 1'b1, "nil flags");
      if (k[0]) chk(acc === m, "copy");
      if (!k[1]) begin
        op = MSTX_OP_XOR_ACC_IMM;
        imm = 8'hff;
        @(negedge clk);
        chk(discard_prefetch === 1'b0 && acc === (k[0] ? m : 8'h5a), "refuse");
      end
      idle();
    end
  endtask : t_skip
  task automatic t_bits();
    logic [7:0] m;
    for (int k = 0; k < 32; k++) begin
      bit_sel = k[2:0];
      m = 8'h01 << k[2:0];
      if (k[3]) m = ~m;
      issue(k[4] ? MSTX_OP_SKIP_WHEN_BIT_SET : MSTX_OP_SKIP_WHEN_BIT_CLR, m, 8'h00);
      chk(discard_prefetch === (k[4] ^ k[3]) && zero_flag === 1'b1, "bit");
      idle();
      idle();
    end
  endtask : t_bits
  task automatic t_table();
    for (int k = 0; k < 2; k++) begin
      pc = 13'h0a5c;
      table_index_reg = 8'h3b;
      issue(k[0] ? MSTX_OP_TABLE_FETCH_FINAL_PAGE : MSTX_OP_TABLE_FETCH_THIS_PAGE, 8'h00, 8'h00);
      chk(rom_re === 1'b1 && busy === 1'b1, "rom read");
      chk(rom_addr === {(k[0] ? 5'h1f : 5'h0a), 8'h3b}, "rom addr");
      rom_rdata = k[0] ? 16'h96c3 : 16'h3c69;
      idle();
      rom_rdata = ~rom_rdata;
      chk(mem_we === 1'b1, "word strobe");
      chk({table_upper_byte_reg, mem_wdata} === ~rom_rdata, "word");
      chk(busy === 1'b0 && zero_flag === 1'b1, "table end");
    end
  endtask : t_table
  // clock enable low freezes the core, held strobes included; a stray code does nothing
  task automatic t_freeze();
    clk_en = 1'b0;
    issue(MSTX_OP_SKIP_WHEN_NIL, 8'h00, 8'h00);
    chk(discard_prefetch === 1'b0 && busy === 1'b0, "frozen take");
    clk_en = 1'b1;
    issue(MSTX_OP_SKIP_WHEN_NIL, 8'h00, 8'h00);
    chk(discard_prefetch === 1'b1 && busy === 1'b1, "late take");
    clk_en = 1'b0;
    idle();
    chk(discard_prefetch === 1'b1 && busy === 1'b1, "frozen dummy");
    clk_en = 1'b1;
    idle();
    chk(discard_prefetch === 1'b0 && busy === 1'b0, "dummy done");
    issue(MSTX_OP_NONE, 8'h00, 8'hff);
    chk(acc === 8'h80 && zero_flag === 1'b1, "no op acc");
    chk(mem_we === 1'b0 && busy === 1'b0, "no op strobes");
    idle();
  endtask : t_freeze
  // main sequence, reset held for ten cycles
  initial begin
    repeat (10) @(negedge clk);
    chk(acc === 8'h00 && zero_flag === 1'b0 && busy === 1'b0, "reset values");
    rst_n = 1'b1;
    @(negedge clk);
    t_xor();
    t_skip();
    t_bits();
    t_table();
    t_freeze();
    wrap_up();
  end
  // hang guard, far beyond the 130 or so cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    $display("FAIL %0t run did not finish", $time);
    err_total++;
    wrap_up();
  end
endmodule : tb_mstx_exec
